// ===== pkg/mc_log_pkg.sv
// Purpose: constants for the bank-four error code logger
// Assumes: AHB-Lite register access, 10 MHz clock
// Notes: register offsets are byte addresses of 32-bit words
package mc_log_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] STAT_LO_OFS = 8'h00;
  localparam logic [7:0] STAT_HI_OFS = 8'h04;
  localparam logic [7:0] CTRL_OFS = 8'h08;
  localparam logic [7:0] INFO_OFS = 8'h0c;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_CLR_BIT = 1;
  localparam logic CTRL_EN_RST = 1'b1;
  // ==========================================================
  // status field positions
  localparam int CODE_LSB = 16;
  localparam int COUNT_LSB = 32;
  localparam int SYN_LSB = 44;
  localparam int SYN_VALID_BIT = 52;
  localparam int UC_BIT = 61;
  localparam int BUS_RSVD_POS = 3;
  // ==========================================================
  // controller codes, selected by a 5-bit source index
  localparam logic [15:0] CBC_CODE [0:18] = '{
    16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0005, 16'h0006,
    16'h0007, 16'h0008, 16'h0009, 16'h0100, 16'h0200, 16'h0300,
    16'h0400, 16'hc001, 16'hc002, 16'hc004, 16'he001, 16'he002,
    16'he004};
  localparam logic [4:0] CBC_LAST = 5'h12;
  localparam logic [4:0] CBC_CORR_FIRST = 5'h0d;
  localparam logic [4:0] CBC_CORR_LAST = 5'h0f;
  // inbound data ECC position within the bus error vector
  localparam int BUS_ECC_IDX = 8;
  localparam int BUS_SRC_N = 11;
  typedef enum logic [1:0] {
    ERR_NONE = 2'b00,
    ERR_BUS = 2'b01,
    ERR_CBC = 2'b10,
    ERR_CACHE = 2'b11
  } err_type_type;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WAIT = 2'b01,
    BUS_DONE = 2'b10
  } bus_state_type;
endpackage

// ===== core/lowest_bit_pick.sv
// Purpose: keep only the lowest set bit of a request vector
// Assumes: purely combinational
// Notes: used so that a logged bus error is always one-hot
`timescale 1ns/1ps
`default_nettype none
module lowest_bit_pick #(
  parameter int N = 12
) (
  input wire logic [N-1:0] req_in,
  output logic [N-1:0] pick_out,
  output logic any_out
);
  logic [N:0] seen;
  if (N < 1) begin : g_chk
    $error("lowest_bit_pick needs N of at least 1");
  end
  assign seen[0] = 1'b0;
  // ==========================================================
  // one bit passes only if no lower bit is set
  for (genvar i = 0; i < N; i++) begin : g_bit
    assign pick_out[i] = req_in[i] & ~seen[i];
    assign seen[i+1] = seen[i] | req_in[i];
  end
  assign any_out = seen[N];
endmodule
`default_nettype wire

// ===== core/sat_counter.sv
// Purpose: saturating event counter
// Assumes: synchronous active-low reset
// Notes: holds at all ones instead of wrapping
`timescale 1ns/1ps
`default_nettype none
module sat_counter #(
  parameter int WIDTH = 8
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic inc_in,
  output logic [WIDTH-1:0] count_out
);
  logic [WIDTH-1:0] count_ff;
  if (WIDTH < 1) begin : g_chk
    $error("sat_counter needs WIDTH of at least 1");
  end
  // ==========================================================
  // count up, stop at the top
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      count_ff <= '0;
    end else if (inc_in && (count_ff != {WIDTH{1'b1}})) begin
      count_ff <= count_ff + 1'b1;
    end
  end
  assign count_out = count_ff;
endmodule
`default_nettype wire

// ===== core/machine_check_error_code_logger.sv
// Purpose: builds the model-specific code and other-info fields of
//   the bank-four status register from three error sources
// Assumes: event inputs are one-cycle pulses synchronous to clk_in
// Notes: registers reached over AHB-Lite, one wait state per access
//
// Our own choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module machine_check_error_code_logger #(
  parameter int COUNT_W = 8
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  // ahb-lite slave
  input wire logic hsel_in,
  input wire logic [7:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // bus and interconnect faults, one bit per detector
  input wire logic bus_req_parity_in,
  input wire logic core0_addr_parity_in,
  input wire logic core1_addr_parity_in,
  input wire logic bus_resp_parity_in,
  input wire logic bus_data_parity_in,
  input wire logic core0_data_parity_in,
  input wire logic core1_data_parity_in,
  input wire logic reply_id_parity_in,
  input wire logic bus_data_ecc_in,
  input wire logic bus_ecc_uncorrectable_in,
  input wire logic data_strobe_glitch_in,
  input wire logic req_strobe_glitch_in,
  // cache bus controller faults
  input wire logic cbc_err_in,
  input wire logic [4:0] cbc_sel_in,
  input wire logic cbc_syn_valid_in,
  input wire logic [7:0] cbc_syndrome_in,
  // cache hierarchy faults
  input wire logic cache_err_in,
  input wire logic [1:0] tag_code_in,
  input wire logic [1:0] data_code_in,
  input wire logic l3_origin_in,
  input wire logic ic_space_access_in,
  input wire logic write_back_type_in
);
  if (COUNT_W != 8) begin : g_chk
    $error("error count field is exactly 8 bits wide");
  end

  // ==========================================================
  // bus error collection
  // detector order follows the code bit order, reserved bit 19 skipped
  logic [mc_log_pkg::BUS_SRC_N-1:0] bus_req;
  logic [mc_log_pkg::BUS_SRC_N-1:0] bus_pick;
  logic bus_any;

  assign bus_req = {req_strobe_glitch_in,
                    data_strobe_glitch_in,
                    bus_data_ecc_in,
                    reply_id_parity_in,
                    core1_data_parity_in,
                    core0_data_parity_in,
                    bus_data_parity_in,
                    bus_resp_parity_in,
                    core1_addr_parity_in,
                    core0_addr_parity_in,
                    bus_req_parity_in};

  // simultaneous detections keep only the lowest bit
  lowest_bit_pick #(
    .N(mc_log_pkg::BUS_SRC_N)
  ) u_pick (
    .req_in(bus_req),
    .pick_out(bus_pick),
    .any_out(bus_any)
  );

  // ==========================================================
  // cache error counter
  logic [COUNT_W-1:0] cache_count;

  // counts every cache error, even one that loses to another source
  sat_counter #(
    .WIDTH(COUNT_W)
  ) u_count (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .inc_in(cache_err_in),
    .count_out(cache_count)
  );

  // ==========================================================
  // register state
  logic [63:0] status_ff;
  logic [63:0] nxt_status;
  logic log_valid_ff;
  logic overwrite_ff;
  logic enable_ff;
  mc_log_pkg::err_type_type type_ff;
  mc_log_pkg::err_type_type nxt_type;
  logic log_now;

  // ==========================================================
  // ahb-lite slave state
  mc_log_pkg::bus_state_type bus_state_ff;
  logic [7:0] addr_ff;
  logic write_ff;
  logic [31:0] hrdata_ff;
  logic hreadyout_ff;
  logic wr_strobe;
  logic clr_req;
  logic take_xfer;

  // ==========================================================
  // controller code lookup
  logic cbc_legal;
  logic cbc_correctable;
  logic [15:0] cbc_code;

  assign cbc_legal = (cbc_sel_in <= mc_log_pkg::CBC_LAST);
  assign cbc_correctable = (cbc_sel_in >= mc_log_pkg::CBC_CORR_FIRST) &&
                           (cbc_sel_in <= mc_log_pkg::CBC_CORR_LAST);
  // an out-of-range index yields nothing rather than a reserved code
  assign cbc_code = cbc_legal ? mc_log_pkg::CBC_CODE[cbc_sel_in] : 16'h0000;

  // ==========================================================
  // next status word, bus errors first, then controller, then cache
  always_comb begin
    nxt_status = 64'h0000_0000_0000_0000;
    nxt_type = mc_log_pkg::ERR_NONE;
    log_now = 1'b0;
    if (enable_ff) begin
      if (bus_any) begin
        log_now = 1'b1;
        nxt_type = mc_log_pkg::ERR_BUS;
        // one-hot pick spread over 27:16, bit 19 left zero
        nxt_status[mc_log_pkg::CODE_LSB +: mc_log_pkg::BUS_RSVD_POS] =
          bus_pick[mc_log_pkg::BUS_RSVD_POS-1:0];
        nxt_status[mc_log_pkg::CODE_LSB + mc_log_pkg::BUS_RSVD_POS + 1 +:
                   mc_log_pkg::BUS_SRC_N - mc_log_pkg::BUS_RSVD_POS] =
          bus_pick[mc_log_pkg::BUS_SRC_N-1:mc_log_pkg::BUS_RSVD_POS];
        // only the inbound ECC event may be correctable
        nxt_status[mc_log_pkg::UC_BIT] =
          bus_pick[mc_log_pkg::BUS_ECC_IDX] ? bus_ecc_uncorrectable_in : 1'b1;
      end else if (cbc_err_in && cbc_legal) begin
        log_now = 1'b1;
        nxt_type = mc_log_pkg::ERR_CBC;
        nxt_status[mc_log_pkg::CODE_LSB +: 16] = cbc_code;
        nxt_status[mc_log_pkg::UC_BIT] = ~cbc_correctable;
        if (cbc_correctable && cbc_syn_valid_in) begin
          nxt_status[mc_log_pkg::SYN_LSB +: 8] = cbc_syndrome_in;
          nxt_status[mc_log_pkg::SYN_VALID_BIT] = 1'b1;
        end
      end else if (cache_err_in) begin
        log_now = 1'b1;
        nxt_type = mc_log_pkg::ERR_CACHE;
        nxt_status[mc_log_pkg::CODE_LSB +: 2] = tag_code_in;
        nxt_status[mc_log_pkg::CODE_LSB + 2 +: 2] = data_code_in;
        nxt_status[mc_log_pkg::CODE_LSB + 4] = l3_origin_in;
        nxt_status[mc_log_pkg::CODE_LSB + 5] =
          ic_space_access_in & write_back_type_in;
        // count before this error, so the first one shows zero
        nxt_status[mc_log_pkg::COUNT_LSB +: COUNT_W] = cache_count;
        nxt_status[mc_log_pkg::UC_BIT] = 1'b1;
      end
    end
  end

  // ==========================================================
  // logged status word; a new error beats a clear in the same cycle
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      status_ff <= 64'h0000_0000_0000_0000;
      type_ff <= mc_log_pkg::ERR_NONE;
    end else if (log_now) begin
      status_ff <= nxt_status;
      type_ff <= nxt_type;
    end else if (clr_req) begin
      status_ff <= 64'h0000_0000_0000_0000;
      type_ff <= mc_log_pkg::ERR_NONE;
    end
  end

  // ==========================================================
  // valid and overwrite flags
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      log_valid_ff <= 1'b0;
      overwrite_ff <= 1'b0;
    end else if (log_now) begin
      log_valid_ff <= 1'b1;
      overwrite_ff <= overwrite_ff | log_valid_ff;
    end else if (clr_req) begin
      log_valid_ff <= 1'b0;
      overwrite_ff <= 1'b0;
    end
  end

  // ==========================================================
  // control register: enable held, clear is a write-one pulse
  assign clr_req = wr_strobe && (addr_ff == mc_log_pkg::CTRL_OFS) &&
                   hwdata_in[mc_log_pkg::CTRL_CLR_BIT];

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      enable_ff <= mc_log_pkg::CTRL_EN_RST;
    end else if (wr_strobe && (addr_ff == mc_log_pkg::CTRL_OFS)) begin
      enable_ff <= hwdata_in[mc_log_pkg::CTRL_EN_BIT];
    end
  end

  // ==========================================================
  // bus handshake: address phase taken, one wait, then the answer
  // the wait lets read data come straight from a flip-flop
  assign take_xfer = hsel_in && hready_in && htrans_in[1];
  assign wr_strobe = (bus_state_ff == mc_log_pkg::BUS_WAIT) && write_ff;

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      bus_state_ff <= mc_log_pkg::BUS_IDLE;
      addr_ff <= 8'h00;
      write_ff <= 1'b0;
      hreadyout_ff <= 1'b1;
    end else begin
      unique case (bus_state_ff)
        mc_log_pkg::BUS_IDLE: begin
          if (take_xfer) begin
            bus_state_ff <= mc_log_pkg::BUS_WAIT;
            addr_ff <= {haddr_in[7:2], 2'b00};
            write_ff <= hwrite_in;
            hreadyout_ff <= 1'b0;
          end
        end
        mc_log_pkg::BUS_WAIT: begin
          bus_state_ff <= mc_log_pkg::BUS_DONE;
          hreadyout_ff <= 1'b1;
        end
        mc_log_pkg::BUS_DONE: begin
          // a pipelined next address phase is taken on this edge
          if (take_xfer) begin
            bus_state_ff <= mc_log_pkg::BUS_WAIT;
            addr_ff <= {haddr_in[7:2], 2'b00};
            write_ff <= hwrite_in;
            hreadyout_ff <= 1'b0;
          end else begin
            bus_state_ff <= mc_log_pkg::BUS_IDLE;
          end
        end
        default: begin
          bus_state_ff <= mc_log_pkg::BUS_IDLE;
          hreadyout_ff <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================================
  // read data, loaded in the wait cycle; unmapped reads give zero
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      hrdata_ff <= 32'h0000_0000;
    end else if ((bus_state_ff == mc_log_pkg::BUS_WAIT) && !write_ff) begin
      unique case (addr_ff)
        mc_log_pkg::STAT_LO_OFS: hrdata_ff <= status_ff[31:0];
        mc_log_pkg::STAT_HI_OFS: hrdata_ff <= status_ff[63:32];
        mc_log_pkg::CTRL_OFS: hrdata_ff <= {31'h0000_0000, enable_ff};
        mc_log_pkg::INFO_OFS: hrdata_ff <= {28'h000_0000, overwrite_ff,
                                            type_ff, log_valid_ff};
        default: hrdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // hsize is not checked: every access is served as a whole word
  assign hrdata_out = hrdata_ff;
  assign hreadyout_out = hreadyout_ff;
  // the answer is always okay, so this is a constant-reset flop
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      hresp_out <= 1'b0;
    end else begin
      hresp_out <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ===== tb/mc_log_checker.sv
// Purpose: port checks for the error code logger
// Assumes: hready_in is tied to hreadyout_out
// Notes: status fields are seen only through register reads
`timescale 1ns/1ps
`default_nettype none
module mc_log_checker (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic hsel_in,
  input wire logic [7:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic hreadyout_out,
  input wire logic hresp_out
);
  // ==========================================================
  // transfer decode
  logic tk;
  logic rd;
  assign tk = hsel_in && hready_in && htrans_in[1];
  assign rd = tk && !hwrite_in;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // ==========================================================
  // bus handshake
  property p_okay; hresp_out == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("error response seen");
  property p_wait; tk |=> !hreadyout_out ##1 hreadyout_out; endproperty
  a_wait: assert property (p_wait) else $error("wait state not one cycle");
  property p_fall; $fell(hreadyout_out) |-> $past(tk); endproperty
  a_fall: assert property (p_fall) else $error("wait state without request");
  property p_hold; $changed(hrdata_out) |-> $past(hreadyout_out) == 1'b0; endproperty
  a_hold: assert property (p_hold) else $error("read data moved outside a read");
  property p_unmap; rd && haddr_in[7:4] != 4'h0 |=> ##1 hrdata_out == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  // ==========================================================
  // status contents
  property p_lo; rd && haddr_in[7:2] == 6'h00 |=> ##1 hrdata_out[15:0] == 16'h0; endproperty
  a_lo: assert property (p_lo) else $error("low code bits not zero");
  property p_hi; rd && haddr_in[7:2] == 6'h01 |=> ##1 (hrdata_out & 32'hdfe00f00) == 32'h0;
  endproperty
  a_hi: assert property (p_hi) else $error("reserved high bits set");
  // a syndrome only comes with a correctable event
  property p_syn; rd && haddr_in[7:2] == 6'h01 |=> ##1 !(hrdata_out[20] && hrdata_out[29]);
  endproperty
  a_syn: assert property (p_syn) else $error("syndrome on uncorrected error");
endmodule
`default_nettype wire

// ===== tb/err_src.sv
// Purpose: error sources of the two cores and the system bus
// Assumes: events are pulses of n cycles taken on clk_in
// Notes: qualifiers are scrambled outside a pulse
`timescale 1ns/1ps
`default_nettype none
module err_src (
  input wire logic clk_in,
  output logic [10:0] bus_err_out,
  output logic ecc_uc_out,
  output logic cbc_err_out,
  output logic [4:0] cbc_sel_out,
  output logic [7:0] syn_out,
  output logic cache_err_out,
  output logic [6:0] cache_q_out
);
  // ==========================================================
  // quiet at time zero
  initial begin
    bus_err_out = 11'h0;
    cbc_err_out = 1'b0;
    cache_err_out = 1'b0;
    {ecc_uc_out, cbc_sel_out, syn_out, cache_q_out} = 21'h0;
  end
  // ==========================================================
  // event held n cycles; qualifiers inverted after, so late sampling shows
  task automatic fire(input logic [10:0] bv, input logic uc, input logic ce,
      input logic [4:0] sel, input logic [7:0] sv, input logic ke,
      input logic [6:0] q, input int n);
    @(posedge clk_in);
    bus_err_out <= bv;
    cbc_err_out <= ce;
    cache_err_out <= ke;
    {ecc_uc_out, cbc_sel_out, syn_out, cache_q_out} <= {uc, sel, sv, q};
    repeat (n) @(posedge clk_in);
    bus_err_out <= 11'h0;
    cbc_err_out <= 1'b0;
    cache_err_out <= 1'b0;
    {ecc_uc_out, cbc_sel_out, syn_out, cache_q_out} <= ~{uc, sel, sv, q};
  endtask
endmodule
`default_nettype wire

// ===== tb/tb_machine_check_error_code_logger.sv
// Purpose: self-checking bench for the error code logger
// Assumes: 10 MHz clock, reset held four cycles
// Notes: every status value is read back over AHB-Lite
`timescale 1ns/1ps
`default_nettype none
module tb_machine_check_error_code_logger;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic hsel_in = 1'b0;
  logic [7:0] haddr_in = 8'h00;
  logic [1:0] htrans_in = 2'h0;
  logic hwrite_in = 1'b0;
  logic [31:0] hwdata_in = 32'h0;
  logic [31:0] hrdata_out;
  logic hreadyout_out;
  logic hresp_out;
  logic [10:0] bus_err;
  logic ecc_uc, cbc_err, cache_err;
  logic [4:0] cbc_sel;
  logic [7:0] syn;
  logic [6:0] cache_q;
  logic [31:0] rd;
  logic syn_valid = 1'b1;
  int err_count = 0;
  int n_tests = 0;
  // ==========================================================
  // clock and instances
  always #50 clk_in = ~clk_in;
  err_src err_src_inst (.clk_in(clk_in), .bus_err_out(bus_err), .ecc_uc_out(ecc_uc),
    .cbc_err_out(cbc_err), .cbc_sel_out(cbc_sel), .syn_out(syn),
    .cache_err_out(cache_err), .cache_q_out(cache_q));
  machine_check_error_code_logger machine_check_error_code_logger_inst (
    .clk_in(clk_in), .nrst_in(nrst_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
    .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(3'h2),
    .hwdata_in(hwdata_in), .hready_in(hreadyout_out), .hrdata_out(hrdata_out),
    .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
    .bus_req_parity_in(bus_err[0]), .core0_addr_parity_in(bus_err[1]),
    .core1_addr_parity_in(bus_err[2]), .bus_resp_parity_in(bus_err[3]),
    .bus_data_parity_in(bus_err[4]), .core0_data_parity_in(bus_err[5]),
    .core1_data_parity_in(bus_err[6]), .reply_id_parity_in(bus_err[7]),
    .bus_data_ecc_in(bus_err[8]), .bus_ecc_uncorrectable_in(ecc_uc),
    .data_strobe_glitch_in(bus_err[9]), .req_strobe_glitch_in(bus_err[10]),
    .cbc_err_in(cbc_err), .cbc_sel_in(cbc_sel), .cbc_syn_valid_in(syn_valid),
    .cbc_syndrome_in(syn), .cache_err_in(cache_err), .tag_code_in(cache_q[1:0]),
    .data_code_in(cache_q[3:2]), .l3_origin_in(cache_q[4]),
    .ic_space_access_in(cache_q[5]), .write_back_type_in(cache_q[6]));
  // ==========================================================
  // shared tasks
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask
  // bounded wait for hready at a rising edge
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (hreadyout_out !== 1'b1 && n < 20);
    if (hreadyout_out !== 1'b1) begin
      err_count++;
      close_out();
    end
  endtask
  // called just after an edge; each transfer ends before the next address phase starts
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel_in <= 1'b1;
    htrans_in <= 2'h2;
    haddr_in <= a;
    hwrite_in <= wr;
    wait_rdy();
    htrans_in <= 2'h0;
    hwdata_in <= wd;
    wait_rdy();
    rd = hrdata_out;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset;
    rd_chk(8'h08, 32'h1);
    rd_chk(8'h04, 32'h0);
    rd_chk(8'h0c, 32'h0);
    ahb(1'b1, 8'h00, 32'hffffffff);
    rd_chk(8'h00, 32'h0);
    rd_chk(8'h10, 32'h0);
  endtask
  task automatic t_bus;
    int p;
    for (int i = 0; i < 12; i++) begin
      p = (i > 10) ? 8 : i;
      err_src_inst.fire(11'h1 << p, i == 8, 1'b0, 5'h0, 8'h0, 1'b0, 7'h0, 1);
      rd_chk(8'h00, 32'h1 << (16 + p + (p > 2)));
      rd_chk(8'h04, {2'b0, i != 11, 29'h0});
    end
    err_src_inst.fire(11'h0a0, 1'b0, 1'b0, 5'h0, 8'h0, 1'b0, 7'h0, 1);
    rd_chk(8'h00, 32'h00400000);
    rd_chk(8'h0c, 32'hb);
  endtask
  task automatic t_cbc;
    logic [15:0] code [0:18];
    logic [7:0] sv;
    logic c;
    code = '{16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0005, 16'h0006, 16'h0007,
      16'h0008, 16'h0009, 16'h0100, 16'h0200, 16'h0300, 16'h0400, 16'hc001,
      16'hc002, 16'hc004, 16'he001, 16'he002, 16'he004};
    for (int s = 0; s < 20; s++) begin
      c = (s > 12 && s < 16);
      sv = 8'(s + 90);
      err_src_inst.fire(11'h0, 1'b0, 1'b1, 5'(s), sv, 1'b0, 7'h0, 1);
      // index 19 is not a code: the previous entry must stand
      rd_chk(8'h00, {(s < 19) ? code[s] : 16'he004, 16'h0});
      rd_chk(8'h04, c ? {11'h0, 1'b1, sv, 12'h0} : 32'h20000000);
    end
    // correctable event without a syndrome leaves the syndrome fields clear
    syn_valid <= 1'b0;
    err_src_inst.fire(11'h0, 1'b0, 1'b1, 5'h0d, 8'h5a, 1'b0, 7'h0, 1);
    rd_chk(8'h00, 32'hc0010000);
    rd_chk(8'h04, 32'h0);
    syn_valid <= 1'b1;
    rd_chk(8'h0c, 32'hd);
  endtask
  task automatic t_cache;
    logic [6:0] q;
    for (int k = 0; k < 16; k++) begin
      q = {k[2:0], k[3:0]};
      err_src_inst.fire(11'h0, 1'b0, 1'b0, 5'h0, 8'h0, 1'b1, q, 1);
      rd_chk(8'h00, {10'h0, q[6] & q[5], q[4:0], 16'h0});
      rd_chk(8'h04, {2'b0, 1'b1, 21'h0, 8'(k)});
    end
    rd_chk(8'h0c, 32'hf);
  endtask
  task automatic t_ctrl;
    // logging off: nothing logged, cache errors still counted
    ahb(1'b1, 8'h08, 32'h0);
    err_src_inst.fire(11'h1, 1'b0, 1'b0, 5'h0, 8'h0, 1'b1, 7'h0, 1);
    rd_chk(8'h00, 32'h003f0000);
    ahb(1'b1, 8'h08, 32'h3);
    rd_chk(8'h00, 32'h0);
    rd_chk(8'h04, 32'h0);
    err_src_inst.fire(11'h8, 1'b0, 1'b1, 5'h0, 8'h0, 1'b1, 7'h0, 1);
    rd_chk(8'h00, 32'h00100000);
    err_src_inst.fire(11'h0, 1'b0, 1'b0, 5'h0, 8'h0, 1'b1, 7'h0, 1);
    rd_chk(8'h04, 32'h20000012);
    err_src_inst.fire(11'h0, 1'b0, 1'b0, 5'h0, 8'h0, 1'b1, 7'h0, 250);
    rd_chk(8'h04, 32'h200000ff);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (4) @(posedge clk_in);
    nrst_in <= 1'b1;
    t_reset();
    t_bus();
    t_cbc();
    t_cache();
    t_ctrl();
    close_out();
  end
endmodule
bind machine_check_error_code_logger mc_log_checker mc_log_checker_inst (
  .clk_in(clk_in), .nrst_in(nrst_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
  .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hready_in(hready_in),
  .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out));
`default_nettype wire
